// ===== cdsc_top.sv
// Clock divide, doze and sleep/idle sequencing
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
module cdsc_top #(
    parameter int RC_STAGES = 8
) (
    input wire logic CLK_IN, // System clock, 20 MHz
    input wire logic SYS_RST_IN, // Any reset source, high
    input wire logic POR_IN, // Power-on reset, high
    input wire logic [3:0] ADDR_IN, // Register index
    input wire logic [15:0] WDATA_IN, // Write data
    input wire logic WR_IN, // Write strobe
    input wire logic RD_IN, // Read strobe
    input wire logic PWR_SAVE_IN, // Power-save instruction executed
    input wire logic IRQ_IN, // Enabled interrupt pending, async
    input wire logic WDT_TO_IN, // Watchdog time-out, async
    input wire logic FAST_RC_EN_IN, // Fast RC oscillator tick enable
    output logic [15:0] RDATA_OUT, // Read data, cycle after strobe
    output logic CPU_EN_OUT, // CPU clock enable
    output logic PERIPH_EN_OUT, // Peripheral clock enable
    output logic SYSCLK_ON_OUT, // System clock source running
    output logic OSC_ON_OUT, // On-chip oscillator running
    output logic LP_RC_ON_OUT, // Low-power RC running
    output logic MONITOR_ON_OUT, // Fail-safe monitor active
    output logic WDT_CLR_OUT, // Watchdog clear pulse
    output logic SWITCH_REQ_OUT, // Clock switch request pulse
    output logic [2:0] CLK_SRC_OUT, // Selected clock source
    output logic FAST_RC_DIV_OUT // Postscaled fast RC tick
);
    // Synchronisers for pin inputs
    logic irq_s1;
    logic irq_s2;
    logic wdt_s1;
    logic wdt_s2;
    always_ff @(posedge CLK_IN)
    begin
        irq_s1 <= IRQ_IN;
        irq_s2 <= irq_s1;
        wdt_s1 <= WDT_TO_IN;
        wdt_s2 <= wdt_s1;
    end

    logic wake;
    assign wake = irq_s2 | wdt_s2;

    // Register state
    logic [15:0] divisor;
    logic [15:0] next_divisor;
    logic [2:0] new_src;
    logic [2:0] next_new_src;
    logic [2:0] cosc;
    logic [2:0] next_cosc;
    logic lock;
    logic next_lock;
    logic wdt_en;
    logic next_wdt_en;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    logic sw_req;
    logic next_sw_req;
    cdsc_pkg::cdsc_mode_t mode;
    cdsc_pkg::cdsc_mode_t next_mode;
    logic [2:0] sleep_src;
    logic [2:0] next_sleep_src;
    logic wdt_clr;
    logic next_wdt_clr;

    // Register writes, interrupt recovery, mode sequencing
    always_comb
    begin
        next_divisor = divisor;
        next_new_src = new_src;
        next_cosc = cosc;
        next_lock = lock;
        next_wdt_en = wdt_en;
        next_sw_req = 1'b0;
        next_mode = mode;
        next_sleep_src = sleep_src;
        next_wdt_clr = 1'b0;
        if (WR_IN && ADDR_IN == cdsc_pkg::ADDR_DIVISOR)
        begin
            next_divisor = WDATA_IN & cdsc_pkg::DIVISOR_WMASK;
        end
        if (divisor[cdsc_pkg::RECOVER_BIT] && irq_s2)
        begin
            next_divisor[cdsc_pkg::REDUCE_EN_BIT] = 1'b0;
        end
        if (WR_IN && ADDR_IN == cdsc_pkg::ADDR_OSCCTL)
        begin
            if (!lock)
            begin
                next_new_src = WDATA_IN[cdsc_pkg::NEWSRC_HI:cdsc_pkg::NEWSRC_LO];
                next_cosc = WDATA_IN[cdsc_pkg::NEWSRC_HI:cdsc_pkg::NEWSRC_LO];
                next_sw_req = 1'b1;
            end
            next_lock = lock | WDATA_IN[cdsc_pkg::LOCK_BIT];
        end
        if (WR_IN && ADDR_IN == cdsc_pkg::ADDR_PSCTL)
        begin
            next_wdt_en = WDATA_IN[cdsc_pkg::WDT_EN_BIT];
        end
        case (mode)
            cdsc_pkg::PM_RUN:
            begin
                if (PWR_SAVE_IN)
                begin
                    if (WDATA_IN[cdsc_pkg::PS_OPERAND_BIT])
                    begin
                        next_mode = cdsc_pkg::PM_SLEEP;
                        next_sleep_src = cosc;
                        next_wdt_clr = wdt_en;
                    end
                    else
                    begin
                        next_mode = cdsc_pkg::PM_IDLE;
                    end
                end
            end
            cdsc_pkg::PM_IDLE,
            cdsc_pkg::PM_SLEEP:
            begin
                if (wake)
                begin
                    next_mode = cdsc_pkg::PM_RUN;
                    if (mode == cdsc_pkg::PM_SLEEP)
                    begin
                        next_cosc = sleep_src;
                    end
                end
            end
            default:
            begin
                next_mode = cdsc_pkg::PM_RUN;
            end
        endcase
    end

    // divisor kept across non power-on resets
    always_ff @(posedge CLK_IN)
    begin
        if (POR_IN)
        begin
            divisor <= cdsc_pkg::DIVISOR_RESET;
        end
        else
        begin
            divisor <= next_divisor;
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN || POR_IN)
        begin
            new_src <= cdsc_pkg::OSC_RESET;
            cosc <= cdsc_pkg::OSC_RESET;
            lock <= 1'b0;
            wdt_en <= 1'b0;
            sw_req <= 1'b0;
            mode <= cdsc_pkg::PM_RUN;
            sleep_src <= cdsc_pkg::OSC_RESET;
            wdt_clr <= 1'b0;
        end
        else
        begin
            new_src <= next_new_src;
            cosc <= next_cosc;
            lock <= next_lock;
            wdt_en <= next_wdt_en;
            sw_req <= next_sw_req;
            mode <= next_mode;
            sleep_src <= next_sleep_src;
            wdt_clr <= next_wdt_clr;
        end
    end

    // Read mux, data in the following cycle
    always_comb
    begin
        next_rdata = cdsc_pkg::REG_ZERO;
        if (RD_IN)
        begin
            case (ADDR_IN)
                cdsc_pkg::ADDR_DIVISOR: next_rdata = divisor;
                cdsc_pkg::ADDR_OSCCTL:
                begin
                    next_rdata[cdsc_pkg::COSC_HI:cdsc_pkg::COSC_LO] = cosc;
                    next_rdata[cdsc_pkg::NEWSRC_HI:cdsc_pkg::NEWSRC_LO] = new_src;
                    next_rdata[cdsc_pkg::LOCK_BIT] = lock;
                end
                cdsc_pkg::ADDR_PSCTL: next_rdata[cdsc_pkg::WDT_EN_BIT] = wdt_en;
                cdsc_pkg::ADDR_STATUS: next_rdata[1:0] = mode;
                default: next_rdata = cdsc_pkg::REG_ZERO;
            endcase
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN || POR_IN)
        begin
            rdata <= cdsc_pkg::REG_ZERO;
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // Doze counter: ratio latched at a CPU clock boundary; clearing the reduce enable drops it at once
    logic [7:0] doze_cnt;
    logic [7:0] next_doze_cnt;
    logic [7:0] doze_lim;
    logic [7:0] next_doze_lim;
    logic cpu_tick;
    always_comb
    begin
        next_doze_cnt = doze_cnt + cdsc_pkg::CNT_ONE;
        next_doze_lim = doze_lim;
        cpu_tick = 1'b0;
        if (doze_cnt >= doze_lim)
        begin
            next_doze_cnt = cdsc_pkg::CNT_ZERO;
            cpu_tick = 1'b1;
            if (divisor[cdsc_pkg::REDUCE_EN_BIT])
            begin
                next_doze_lim = 8'((9'h001 << divisor[cdsc_pkg::DOZE_HI:cdsc_pkg::DOZE_LO]) - 9'h001);
            end
            else
            begin
                next_doze_lim = cdsc_pkg::CNT_ZERO;
            end
        end
        if (!divisor[cdsc_pkg::REDUCE_EN_BIT] && doze_lim != cdsc_pkg::CNT_ZERO)
        begin
            next_doze_cnt = cdsc_pkg::CNT_ZERO;
            next_doze_lim = cdsc_pkg::CNT_ZERO;
        end
    end

    // Fast RC postscaler
    logic [RC_STAGES-1:0] rc_cnt;
    logic [RC_STAGES-1:0] next_rc_cnt;
    logic rc_tick;
    always_comb
    begin
        next_rc_cnt = rc_cnt;
        rc_tick = 1'b0;
        if (FAST_RC_EN_IN)
        begin
            next_rc_cnt = rc_cnt + RC_STAGES'(1);
            if (rc_cnt >= RC_STAGES'((9'h001 << divisor[cdsc_pkg::FAST_RC_HI:cdsc_pkg::FAST_RC_LO]) - 9'h001))
            begin
                next_rc_cnt = '0;
                rc_tick = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN || POR_IN)
        begin
            doze_cnt <= cdsc_pkg::CNT_ZERO;
            doze_lim <= cdsc_pkg::CNT_ZERO;
            rc_cnt <= '0;
        end
        else
        begin
            doze_cnt <= next_doze_cnt;
            doze_lim <= next_doze_lim;
            rc_cnt <= next_rc_cnt;
        end
    end

    // Gate outputs from mode and divider state
    cdsc_pkg::cdsc_ctl_t ctl;
    cdsc_pkg::cdsc_ctl_t next_ctl;
    logic next_rc_out;
    logic rc_out;
    always_comb
    begin
        next_ctl.cpu_en = (next_mode == cdsc_pkg::PM_RUN) && cpu_tick;
        next_ctl.periph_en = next_mode != cdsc_pkg::PM_SLEEP;
        next_ctl.sysclk_on = next_mode != cdsc_pkg::PM_SLEEP;
        next_ctl.osc_on = next_mode != cdsc_pkg::PM_SLEEP;
        next_ctl.lp_rc_on = next_wdt_en || next_mode != cdsc_pkg::PM_SLEEP;
        next_ctl.monitor_on = next_mode != cdsc_pkg::PM_SLEEP;
        next_ctl.wdt_clr = next_wdt_clr;
        next_ctl.switch_req = next_sw_req;
        next_rc_out = rc_tick && next_mode != cdsc_pkg::PM_SLEEP;
    end

    always_ff @(posedge CLK_IN)
    begin
        if (SYS_RST_IN || POR_IN)
        begin
            ctl <= '0;
            rc_out <= 1'b0;
        end
        else
        begin
            ctl <= next_ctl;
            rc_out <= next_rc_out;
        end
    end

    assign RDATA_OUT = rdata;
    assign CPU_EN_OUT = ctl.cpu_en;
    assign PERIPH_EN_OUT = ctl.periph_en;
    assign SYSCLK_ON_OUT = ctl.sysclk_on;
    assign OSC_ON_OUT = ctl.osc_on;
    assign LP_RC_ON_OUT = ctl.lp_rc_on;
    assign MONITOR_ON_OUT = ctl.monitor_on;
    assign WDT_CLR_OUT = ctl.wdt_clr;
    assign SWITCH_REQ_OUT = ctl.switch_req;
    assign CLK_SRC_OUT = cosc;
    assign FAST_RC_DIV_OUT = rc_out;
endmodule

// ===== cdsc_pkg.sv
// Package for the clock divide and sleep control block
package cdsc_pkg;
    // Register indices on the plain port
    localparam logic [3:0] ADDR_DIVISOR = 4'h0;
    localparam logic [3:0] ADDR_OSCCTL = 4'h1;
    localparam logic [3:0] ADDR_PSCTL = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    // Divisor register fields
    localparam int RECOVER_BIT = 15;
    localparam int DOZE_HI = 14;
    localparam int DOZE_LO = 12;
    localparam int REDUCE_EN_BIT = 11;
    localparam int FAST_RC_HI = 10;
    localparam int FAST_RC_LO = 8;
    localparam logic [15:0] DIVISOR_RESET = 16'h3040;
    localparam logic [15:0] DIVISOR_WMASK = 16'hffdf;
    // Oscillator control fields
    localparam int NEWSRC_HI = 10;
    localparam int NEWSRC_LO = 8;
    localparam int COSC_HI = 14;
    localparam int COSC_LO = 12;
    localparam int LOCK_BIT = 7;
    localparam logic [2:0] OSC_RESET = 3'h7;
    // Power-save control fields
    localparam int PS_OPERAND_BIT = 0;
    localparam int WDT_EN_BIT = 1;
    localparam logic [15:0] REG_ZERO = 16'h0000;
    localparam logic [7:0] CNT_ZERO = 8'h00;
    localparam logic [7:0] CNT_ONE = 8'h01;

    typedef enum logic [1:0] {
        PM_RUN,
        PM_IDLE,
        PM_SLEEP
    } cdsc_mode_t;

    // Clock gate and pulse outputs that travel together
    typedef struct packed {
        logic cpu_en;
        logic periph_en;
        logic sysclk_on;
        logic osc_on;
        logic lp_rc_on;
        logic monitor_on;
        logic wdt_clr;
        logic switch_req;
    } cdsc_ctl_t;
endpackage

// ===== cdsc_sva.sv
// Assertion checker for the clock divide and sleep block
`timescale 1ns/1ns
module cdsc_sva (
    input wire logic CLK_IN, // Clock
    input wire logic SYS_RST_IN, // Reset
    input wire logic POR_IN, // Power-on reset
    input wire logic [3:0] ADDR_IN, // Index
    input wire logic [15:0] WDATA_IN, // Data
    input wire logic WR_IN, // Write
    input wire logic PWR_SAVE_IN, // Power save
    input wire logic IRQ_IN, // Interrupt
    input wire logic CPU_EN_OUT, // CPU tick
    input wire logic PERIPH_EN_OUT, // Peripheral
    input wire logic SYSCLK_ON_OUT, // Source on
    input wire logic OSC_ON_OUT, // Oscillator
    input wire logic LP_RC_ON_OUT, // Low-power RC
    input wire logic MONITOR_ON_OUT, // Monitor
    input wire logic WDT_CLR_OUT, // Watchdog clear
    input wire logic SWITCH_REQ_OUT, // Switch
    input wire logic [2:0] CLK_SRC_OUT // Source
);
    logic wdt_en, lock, next_wdt_en, next_lock, osc_wr;
    assign osc_wr = WR_IN && ADDR_IN == cdsc_pkg::ADDR_OSCCTL;
    // Shadow of watchdog enable and sticky lock
    always_comb
    begin
        next_lock = lock | (osc_wr & WDATA_IN[cdsc_pkg::LOCK_BIT]);
        next_wdt_en = wdt_en;
        if (WR_IN && ADDR_IN == cdsc_pkg::ADDR_PSCTL)
        begin
            next_wdt_en = WDATA_IN[cdsc_pkg::WDT_EN_BIT];
        end
    end
    always_ff @(posedge CLK_IN)
    begin
        wdt_en <= (SYS_RST_IN || POR_IN) ? 1'b0 : next_wdt_en;
        lock <= (SYS_RST_IN || POR_IN) ? 1'b0 : next_lock;
    end
    default clocking @(posedge CLK_IN);
    endclocking
    default disable iff (SYS_RST_IN || POR_IN);
    sequence s_sleep_cmd;
        PWR_SAVE_IN && WDATA_IN[0] && SYSCLK_ON_OUT;
    endsequence
    sequence s_idle_cmd;
        PWR_SAVE_IN && !WDATA_IN[0] && SYSCLK_ON_OUT && !IRQ_IN;
    endsequence
    property p_sleep;
        s_sleep_cmd |=> !SYSCLK_ON_OUT && !OSC_ON_OUT && !PERIPH_EN_OUT && !CPU_EN_OUT;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep entry wrong");
    property p_idle;
        s_idle_cmd |=> PERIPH_EN_OUT && SYSCLK_ON_OUT && !CPU_EN_OUT;
    endproperty
    a_idle: assert property (p_idle) else $error("idle entry wrong");
    property p_monitor;
        !SYSCLK_ON_OUT |-> !MONITOR_ON_OUT;
    endproperty
    a_monitor: assert property (p_monitor) else $error("monitor on in sleep");
    property p_lp_rc;
        wdt_en && !SYSCLK_ON_OUT |-> LP_RC_ON_OUT;
    endproperty
    a_lp_rc: assert property (p_lp_rc) else $error("low-power RC off");
    property p_wdt_clr;
        s_sleep_cmd ##0 wdt_en |=> WDT_CLR_OUT ##1 !WDT_CLR_OUT;
    endproperty
    a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog clear missing");
    property p_wake;
        !SYSCLK_ON_OUT ##1 $rose(IRQ_IN) |-> ##[1:5] SYSCLK_ON_OUT;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on interrupt");
    property p_src;
        !$past(SYSCLK_ON_OUT) |-> $stable(CLK_SRC_OUT);
    endproperty
    a_src: assert property (p_src) else $error("source moved over sleep");
    property p_switch;
        osc_wr && !lock |=> SWITCH_REQ_OUT && CLK_SRC_OUT == $past(WDATA_IN[10:8]);
    endproperty
    a_switch: assert property (p_switch) else $error("switch not done");
    property p_lock;
        osc_wr && lock |=> !SWITCH_REQ_OUT && $stable(CLK_SRC_OUT);
    endproperty
    a_lock: assert property (p_lock) else $error("locked switch done");
    property p_cpu_periph;
        CPU_EN_OUT |-> PERIPH_EN_OUT;
    endproperty
    a_cpu_periph: assert property (p_cpu_periph) else $error("CPU runs alone");
endmodule
bind cdsc_top cdsc_sva chk_u (.CLK_IN, .SYS_RST_IN, .POR_IN, .ADDR_IN, .WDATA_IN, .WR_IN, .PWR_SAVE_IN,
    .IRQ_IN, .CPU_EN_OUT, .PERIPH_EN_OUT, .SYSCLK_ON_OUT, .OSC_ON_OUT, .LP_RC_ON_OUT, .MONITOR_ON_OUT,
    .WDT_CLR_OUT, .SWITCH_REQ_OUT, .CLK_SRC_OUT);

// ===== testbench.sv
// Self-checking bench for the clock divide and sleep block
`timescale 1ns/1ns
module testbench;
    logic CLK_IN = 1'b0;
    logic SYS_RST_IN = 1'b1;
    logic POR_IN = 1'b1;
    logic [3:0] ADDR_IN = 4'h0;
    logic [15:0] WDATA_IN = 16'h0000;
    logic WR_IN = 1'b0;
    logic RD_IN = 1'b0;
    logic PWR_SAVE_IN = 1'b0;
    logic IRQ_IN = 1'b0;
    logic WDT_TO_IN = 1'b0;
    logic FAST_RC_EN_IN = 1'b1;
    logic [15:0] RDATA_OUT, d, c, f;
    logic CPU_EN_OUT, PERIPH_EN_OUT, SYSCLK_ON_OUT, OSC_ON_OUT, LP_RC_ON_OUT, MONITOR_ON_OUT;
    logic WDT_CLR_OUT, SWITCH_REQ_OUT, FAST_RC_DIV_OUT, s, w;
    logic [2:0] CLK_SRC_OUT, o;
    int n_fail = 0;
    int tests_run = 0;
    cdsc_top dut_u (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN), .POR_IN(POR_IN), .ADDR_IN(ADDR_IN),
        .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN), .PWR_SAVE_IN(PWR_SAVE_IN), .IRQ_IN(IRQ_IN),
        .WDT_TO_IN(WDT_TO_IN), .FAST_RC_EN_IN(FAST_RC_EN_IN), .RDATA_OUT(RDATA_OUT), .CPU_EN_OUT(CPU_EN_OUT),
        .PERIPH_EN_OUT(PERIPH_EN_OUT), .SYSCLK_ON_OUT(SYSCLK_ON_OUT), .OSC_ON_OUT(OSC_ON_OUT),
        .LP_RC_ON_OUT(LP_RC_ON_OUT), .MONITOR_ON_OUT(MONITOR_ON_OUT), .WDT_CLR_OUT(WDT_CLR_OUT),
        .SWITCH_REQ_OUT(SWITCH_REQ_OUT), .CLK_SRC_OUT(CLK_SRC_OUT), .FAST_RC_DIV_OUT(FAST_RC_DIV_OUT));
    // Clock, 50 ns period
    always #25 CLK_IN = ~CLK_IN;
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [3:0] a, logic [15:0] v);
        ADDR_IN <= a;
        WDATA_IN <= v;
        WR_IN <= 1'b1;
        @(posedge CLK_IN);
        WR_IN <= 1'b0;
        @(posedge CLK_IN);
    endtask
    task automatic rd(logic [3:0] a, logic [15:0] e);
        ADDR_IN <= a;
        RD_IN <= 1'b1;
        @(posedge CLK_IN);
        RD_IN <= 1'b0;
        @(posedge CLK_IN);
        chk("rdata", e, RDATA_OUT);
    endtask
    task automatic pulse_rst(input bit por);
        if (por)
            POR_IN <= 1'b1;
        else
            SYS_RST_IN <= 1'b1;
        @(posedge CLK_IN);
        POR_IN <= 1'b0;
        SYS_RST_IN <= 1'b0;
        @(posedge CLK_IN);
    endtask
    // Pulse counts over 1024 cycles
    task automatic count();
        c = 16'h0000;
        f = 16'h0000;
        repeat (1024)
        begin
            @(posedge CLK_IN);
            c = c + {15'h0000, CPU_EN_OUT};
            f = f + {15'h0000, FAST_RC_DIV_OUT};
        end
    endtask
    function automatic logic [15:0] rate(logic [2:0] k);
        return 16'h0400 >> k;
    endfunction
    // Hang guard
    initial
    begin
        #(50 * 40000);
        n_fail++;
        summarize();
    end
    // Main sequence
    initial
    begin
        void'($urandom(67));
        repeat (5) @(posedge CLK_IN);
        SYS_RST_IN <= 1'b0;
        POR_IN <= 1'b0;
        @(posedge CLK_IN);
        rd(cdsc_pkg::ADDR_DIVISOR, 16'h3040);
        rd(4'hf, 16'h0000);
        d = 16'($urandom);
        wr(cdsc_pkg::ADDR_DIVISOR, d);
        pulse_rst(1'b0);
        rd(cdsc_pkg::ADDR_DIVISOR, d & 16'hffdf);
        for (int k = 0; k < 9; k++)
        begin
            wr(cdsc_pkg::ADDR_DIVISOR, {1'b0, k[2:0], k < 8, k[2:0], 8'h00});
            repeat (300) @(posedge CLK_IN);
            count();
            chk("cpu_rate", (k < 8) ? rate(k[2:0]) : 16'h0400, c);
            chk("frc_rate", rate(k[2:0]), f);
        end
        for (int r = 0; r < 2; r++)
        begin
            wr(cdsc_pkg::ADDR_DIVISOR, {r[0], 15'h3800});
            IRQ_IN <= 1'b1;
            repeat (5) @(posedge CLK_IN);
            IRQ_IN <= 1'b0;
            repeat (3) @(posedge CLK_IN);
            rd(cdsc_pkg::ADDR_DIVISOR, {r[0], 3'h3, ~r[0], 11'h000});
        end
        o = 3'($urandom);
        wr(cdsc_pkg::ADDR_OSCCTL, {5'h00, o, 8'h00});
        chk("src", {13'h0000, o}, {13'h0000, CLK_SRC_OUT});
        for (int m = 0; m < 6; m++)
        begin
            s = (m < 3);
            w = 1'($urandom);
            wr(cdsc_pkg::ADDR_PSCTL, {14'h0000, w, 1'b0});
            PWR_SAVE_IN <= 1'b1;
            WDATA_IN <= {15'h0000, s};
            @(posedge CLK_IN);
            PWR_SAVE_IN <= 1'b0;
            @(posedge CLK_IN);
            chk("gates", {8'h00, 1'b0, ~s, ~s, ~s, ~s, ~s | w, ~s, s & w}, {8'h00, CPU_EN_OUT, FAST_RC_DIV_OUT,
                PERIPH_EN_OUT, SYSCLK_ON_OUT, OSC_ON_OUT, LP_RC_ON_OUT, MONITOR_ON_OUT,
                WDT_CLR_OUT});
            rd(cdsc_pkg::ADDR_STATUS, {14'h0000, s, ~s});
            rd(cdsc_pkg::ADDR_PSCTL, {14'h0000, w, 1'b0});
            IRQ_IN <= (m % 3 == 0);
            WDT_TO_IN <= (m % 3 == 1);
            SYS_RST_IN <= (m % 3 == 2);
            repeat (4) @(posedge CLK_IN);
            IRQ_IN <= 1'b0;
            WDT_TO_IN <= 1'b0;
            SYS_RST_IN <= 1'b0;
            repeat (4) @(posedge CLK_IN);
            o = (m % 3 == 2) ? cdsc_pkg::OSC_RESET : o;
            chk("wake", 16'h001f, {11'h000, PERIPH_EN_OUT, SYSCLK_ON_OUT, OSC_ON_OUT, LP_RC_ON_OUT,
                MONITOR_ON_OUT});
            chk("wake_src", {13'h0000, o}, {13'h0000, CLK_SRC_OUT});
        end
        wr(cdsc_pkg::ADDR_OSCCTL, {5'h00, o ^ 3'h1, 8'h80});
        o = o ^ 3'h1;
        wr(cdsc_pkg::ADDR_OSCCTL, {5'h00, ~o, 8'h00});
        chk("locked", {13'h0000, o}, {13'h0000, CLK_SRC_OUT});
        pulse_rst(1'b1);
        rd(cdsc_pkg::ADDR_DIVISOR, 16'h3040);
        summarize();
    end
endmodule
